//--- pesl_map.vh
/*
 * Register offsets, field positions, reset values and timing counts for
 * the ESD counter, SGMII timer/status and indicator light register slice.
 * Assumes a 250 MHz core clock and 16-bit register words.
 */
`ifndef PESL_MAP_VH
`define PESL_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PESL_ADDR_W 11
`define PESL_OFF_ESD 11'h448
`define PESL_OFF_SGT 11'h456
`define PESL_OFF_SGS 11'h459
`define PESL_OFF_LED 11'h460
`define PESL_OFF_IRQ_STAT 11'h470
`define PESL_OFF_IRQ_MASK 11'h471
`define PESL_OFF_BMSR 11'h001

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PESL_ESD_MAC_HI 13
`define PESL_ESD_MAC_LO 8
`define PESL_ESD_LINE_HI 5
`define PESL_ESD_LINE_LO 0
`define PESL_SGT_HI 13
`define PESL_SGT_LO 12
`define PESL_SGT_RST 2'h1
`define PESL_SGT_LOW_RST 12'h008
`define PESL_SGS_PAGE 1
`define PESL_SGS_DONE 0
`define PESL_LED_RATE_HI 13
`define PESL_LED_RATE_LO 12
`define PESL_LED_RST 16'h2610
`define PESL_LED_RW_MASK 16'hFFFF
`define PESL_IRQ_W 4

// ----------------------------------------------------------------------
// Indicator source codes
// ----------------------------------------------------------------------
`define PESL_SRC_LINK 4'h0
`define PESL_SRC_LINK_ACT 4'h1
`define PESL_SRC_LINK_TX 4'h2
`define PESL_SRC_LINK_TX2 4'h3
`define PESL_SRC_LINK_RX 4'h4
`define PESL_SRC_LINK_SLV 4'h5
`define PESL_SRC_ACT 4'h6
`define PESL_SRC_LOST 4'h9
`define PESL_SRC_PRBS 4'hA
`define PESL_MUX_LED 3'h0

// ----------------------------------------------------------------------
// Timing: timer times in microseconds, blink times in milliseconds, counts at 250 cycles per microsecond
// ----------------------------------------------------------------------
`define PESL_CYC_PER_US 250
`define PESL_SGT_T0_US 1600
`define PESL_SGT_T1_US 2
`define PESL_SGT_T2_US 800
`define PESL_SGT_T3_US 11000
`define PESL_SGT_CYC(us) ((us) * `PESL_CYC_PER_US)
`define PESL_BLINK_T0_MS 50
`define PESL_BLINK_T1_MS 100
`define PESL_BLINK_T2_MS 200
`define PESL_BLINK_T3_MS 500
`define PESL_CYC_PER_MS 250000
`define PESL_HALF_CYC(ms) ((ms) * `PESL_CYC_PER_MS / 2)

`endif

//--- pesl_sync.v
/*
 * Two flip-flop synchroniser for one level signal.
 * Assumes the input is asynchronous to core_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module pesl_sync (
	// Clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// Data
	input wire d_i,
	output wire q_o
);

reg meta_ff;
reg sync_ff;

always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		meta_ff <= 1'b0;
		sync_ff <= 1'b0;
	end else begin
		meta_ff <= d_i;
		sync_ff <= meta_ff;
	end
end

assign q_o = sync_ff;

endmodule

`default_nettype wire

//--- pesl_light.v
/*
 * One indicator light: source decode per 4-bit selector and pin mux gate.
 * Assumes synchronised status inputs and a shared blink phase.
 */
`timescale 1ns/1ps
`default_nettype none

`include "pesl_map.vh"

module pesl_light (
	// Clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// Selection
	input wire [3:0] src_i,
	input wire [2:0] mux_sel_i,
	// Status
	input wire link_i,
	input wire tx_act_i,
	input wire rx_act_i,
	input wire slave_i,
	input wire blink_i,
	input wire lost_i,
	input wire prbs_i,
	// Light
	output reg light_o
);

reg nxt_light;

always @* begin
	case (src_i)
	`PESL_SRC_LINK: nxt_light = link_i;
	`PESL_SRC_LINK_ACT: nxt_light = link_i & ~((tx_act_i | rx_act_i) & blink_i);
	`PESL_SRC_LINK_TX: nxt_light = link_i & tx_act_i;
	`PESL_SRC_LINK_TX2: nxt_light = link_i & tx_act_i;
	`PESL_SRC_LINK_RX: nxt_light = link_i & rx_act_i;
	`PESL_SRC_LINK_SLV: nxt_light = link_i & slave_i;
	`PESL_SRC_ACT: nxt_light = tx_act_i | rx_act_i;
	`PESL_SRC_LOST: nxt_light = lost_i;
	`PESL_SRC_PRBS: nxt_light = prbs_i;
	default: nxt_light = 1'b0;
	endcase
	if (mux_sel_i != `PESL_MUX_LED) begin
		nxt_light = 1'b0;
	end
end

always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		light_o <= 1'b0;
	end else begin
		light_o <= nxt_light;
	end
end

endmodule

`default_nettype wire

//--- pesl_regs.v
/*
 * ESD event counters, SGMII negotiation timer and status, indicator light
 * configuration, interrupt status/mask, and three indicator outputs.
 * Assumes a simple register port with read data one cycle after the strobe,
 * a power-on reset separate from the hardware reset, and asynchronous
 * event and status pins that are synchronised here.
 */
// Summary of operation
// - Bits 13:8 of the ESD register count ESD hits on the MAC-side port.
// - Bits 5:0 of the ESD register count ESD hits on the line pair.
// - Every synchronised rising edge counts, with no dead time.
// - ESD counts clear only on power-up, never on hardware reset.
// - Timer field 13:12 picks 1.6 ms, 2 us, 800 us or 11 ms; resets to 01.
// - SGMII status bit 1 reads 1 when a new page arrived.
// - SGMII status bit 0 reads 1 when negotiation completed.
// - Light field 13:12 picks a 50, 100, 200 or 500 ms blink period.
// - Codes 0000, 0001 and 0110 give link, link+blink, activity.
// - Code 0101 shows link up in the slave role.
// - Code 1001 lights on link loss until status register 0x1 is read.
// - Code 1010 lights on any PRBS error until that counter clears.
// - Second and third lights use 7:4 and 11:8, reset 0001 and 0110.
// - A light shows its source only while its pin mux select is 000.
`timescale 1ns/1ps
`default_nettype none

`include "pesl_map.vh"

module pesl_regs (
	// Clock and resets
	input wire core_clk_i,
	input wire rst_i,
	input wire por_i,
	// Register port
	input wire [`PESL_ADDR_W-1:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	// Event pins and pin mux selects
	input wire esd_mac_i,
	input wire esd_line_i,
	input wire sg_page_i,
	input wire sg_done_i,
	input wire link_i,
	input wire tx_act_i,
	input wire rx_act_i,
	input wire slave_i,
	input wire prbs_err_i,
	input wire prbs_clr_i,
	input wire [2:0] mux_first_i,
	input wire [2:0] mux_second_i,
	input wire [2:0] mux_third_i,
	// Outputs
	output reg [1:0] sgmii_timer_sel_o,
	output reg sgmii_timer_tick_o,
	output wire indicator_first_o,
	output wire indicator_second_o,
	output wire indicator_third_o,
	output reg irq_o
);

localparam [31:0] SGT_C0 = `PESL_SGT_CYC(`PESL_SGT_T0_US);
localparam [31:0] SGT_C1 = `PESL_SGT_CYC(`PESL_SGT_T1_US);
localparam [31:0] SGT_C2 = `PESL_SGT_CYC(`PESL_SGT_T2_US);
localparam [31:0] SGT_C3 = `PESL_SGT_CYC(`PESL_SGT_T3_US);
localparam [31:0] BLK_C0 = `PESL_HALF_CYC(`PESL_BLINK_T0_MS);
localparam [31:0] BLK_C1 = `PESL_HALF_CYC(`PESL_BLINK_T1_MS);
localparam [31:0] BLK_C2 = `PESL_HALF_CYC(`PESL_BLINK_T2_MS);
localparam [31:0] BLK_C3 = `PESL_HALF_CYC(`PESL_BLINK_T3_MS);

// ----------------------------------------------------------------------
// Synchronisers
// ----------------------------------------------------------------------
wire [7:0] raw_w;
wire [7:0] syn_w;
assign raw_w = {prbs_clr_i, prbs_err_i, slave_i, rx_act_i, tx_act_i,
	link_i, sg_done_i, sg_page_i};

genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
		pesl_sync u_sync (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.d_i(raw_w[gi]),
			.q_o(syn_w[gi])
		);
	end
endgenerate

wire esd_line_s;
pesl_sync u_sync_line (
	.core_clk_i(core_clk_i),
	.rst_i(por_i),
	.d_i(esd_line_i),
	.q_o(esd_line_s)
);

// ESD syncs for counters run on power-on reset only
wire esd_mac_s;
pesl_sync u_sync_mac (
	.core_clk_i(core_clk_i),
	.rst_i(por_i),
	.d_i(esd_mac_i),
	.q_o(esd_mac_s)
);

wire sg_page_s = syn_w[0];
wire sg_done_s = syn_w[1];
wire link_s = syn_w[2];
wire tx_s = syn_w[3];
wire rx_s = syn_w[4];
wire slave_s = syn_w[5];
wire prbs_s = syn_w[6];
wire prbs_clr_s = syn_w[7];

// ----------------------------------------------------------------------
// ESD counters (power-on reset only)
// ----------------------------------------------------------------------
reg [5:0] esd_mac_ff;
reg [5:0] esd_line_ff;
reg esd_mac_d_ff;
reg esd_line_d_ff;
wire esd_mac_hit = esd_mac_s & ~esd_mac_d_ff;
wire esd_line_hit = esd_line_s & ~esd_line_d_ff;

always @(posedge core_clk_i or posedge por_i) begin
	if (por_i) begin
		esd_mac_ff <= 6'h00;
		esd_line_ff <= 6'h00;
		esd_mac_d_ff <= 1'b0;
		esd_line_d_ff <= 1'b0;
	end else begin
		esd_mac_d_ff <= esd_mac_s;
		esd_line_d_ff <= esd_line_s;
		if (esd_mac_hit) begin
			esd_mac_ff <= esd_mac_ff + 6'h01;
		end
		if (esd_line_hit) begin
			esd_line_ff <= esd_line_ff + 6'h01;
		end
	end
end

// ----------------------------------------------------------------------
// Writable registers
// ----------------------------------------------------------------------
reg [1:0] sgt_sel_ff;
reg [15:0] led_cfg_ff;
reg [`PESL_IRQ_W-1:0] irq_mask_ff;
reg [`PESL_IRQ_W-1:0] irq_stat_ff;
reg lost_ff;
reg prbs_ff;
reg link_d_ff;
reg sg_page_d_ff;
reg sg_done_d_ff;

wire wr_sgt = wr_i & (addr_i == `PESL_OFF_SGT);
wire wr_led = wr_i & (addr_i == `PESL_OFF_LED);
wire wr_mask = wr_i & (addr_i == `PESL_OFF_IRQ_MASK);
wire wr_stat = wr_i & (addr_i == `PESL_OFF_IRQ_STAT);
wire rd_bmsr = rd_i & (addr_i == `PESL_OFF_BMSR);
wire link_fall = link_d_ff & ~link_s;
wire [`PESL_IRQ_W-1:0] irq_ev;
assign irq_ev = {link_fall, sg_done_s & ~sg_done_d_ff,
	sg_page_s & ~sg_page_d_ff, esd_mac_hit | esd_line_hit};

always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		sgt_sel_ff <= `PESL_SGT_RST;
		led_cfg_ff <= `PESL_LED_RST;
		irq_mask_ff <= {`PESL_IRQ_W{1'b0}};
		irq_stat_ff <= {`PESL_IRQ_W{1'b0}};
		lost_ff <= 1'b0;
		prbs_ff <= 1'b0;
		link_d_ff <= 1'b0;
		sg_page_d_ff <= 1'b0;
		sg_done_d_ff <= 1'b0;
	end else begin
		link_d_ff <= link_s;
		sg_page_d_ff <= sg_page_s;
		sg_done_d_ff <= sg_done_s;
		if (wr_sgt) begin
			sgt_sel_ff <= wdata_i[`PESL_SGT_HI:`PESL_SGT_LO];
		end
		if (wr_led) begin
			led_cfg_ff <= wdata_i & `PESL_LED_RW_MASK;
		end
		if (wr_mask) begin
			irq_mask_ff <= wdata_i[`PESL_IRQ_W-1:0];
		end
		// Set wins over write-one-to-clear
		irq_stat_ff <= (irq_stat_ff &
			~(wr_stat ? wdata_i[`PESL_IRQ_W-1:0] : {`PESL_IRQ_W{1'b0}}))
			| irq_ev;
		// Latched link loss, cleared by a status read, new loss wins
		if (link_fall) begin
			lost_ff <= 1'b1;
		end else if (rd_bmsr) begin
			lost_ff <= 1'b0;
		end
		if (prbs_s) begin
			prbs_ff <= 1'b1;
		end else if (prbs_clr_s) begin
			prbs_ff <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------------
// Blink divider and SGMII link timer tick
// ----------------------------------------------------------------------
reg [31:0] blk_cnt_ff;
reg blink_ff;
reg [31:0] blk_lim;
reg [31:0] sgt_cnt_ff;
reg [31:0] sgt_lim;

always @* begin
	case (led_cfg_ff[`PESL_LED_RATE_HI:`PESL_LED_RATE_LO])
	2'h0: blk_lim = BLK_C0;
	2'h1: blk_lim = BLK_C1;
	2'h2: blk_lim = BLK_C2;
	default: blk_lim = BLK_C3;
	endcase
	case (sgt_sel_ff)
	2'h0: sgt_lim = SGT_C0;
	2'h1: sgt_lim = SGT_C1;
	2'h2: sgt_lim = SGT_C2;
	default: sgt_lim = SGT_C3;
	endcase
end

always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		blk_cnt_ff <= 32'h0;
		blink_ff <= 1'b0;
		sgt_cnt_ff <= 32'h0;
		sgmii_timer_tick_o <= 1'b0;
		sgmii_timer_sel_o <= `PESL_SGT_RST;
	end else begin
		sgmii_timer_sel_o <= sgt_sel_ff;
		if (blk_cnt_ff + 32'h1 >= blk_lim) begin
			blk_cnt_ff <= 32'h0;
			blink_ff <= ~blink_ff;
		end else begin
			blk_cnt_ff <= blk_cnt_ff + 32'h1;
		end
		if (sgt_cnt_ff + 32'h1 >= sgt_lim) begin
			sgt_cnt_ff <= 32'h0;
			sgmii_timer_tick_o <= 1'b1;
		end else begin
			sgt_cnt_ff <= sgt_cnt_ff + 32'h1;
			sgmii_timer_tick_o <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------------
// Indicator lights
// ----------------------------------------------------------------------
wire [3:0] src_w [0:2];
wire [2:0] mux_w [0:2];
wire [2:0] light_w;
assign src_w[0] = led_cfg_ff[3:0];
assign src_w[1] = led_cfg_ff[7:4];
assign src_w[2] = led_cfg_ff[11:8];
assign mux_w[0] = mux_first_i;
assign mux_w[1] = mux_second_i;
assign mux_w[2] = mux_third_i;

generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_light
		pesl_light u_light (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.src_i(src_w[gi]),
			.mux_sel_i(mux_w[gi]),
			.link_i(link_s),
			.tx_act_i(tx_s),
			.rx_act_i(rx_s),
			.slave_i(slave_s),
			.blink_i(blink_ff),
			.lost_i(lost_ff),
			.prbs_i(prbs_ff),
			.light_o(light_w[gi])
		);
	end
endgenerate

assign indicator_first_o = light_w[0];
assign indicator_second_o = light_w[1];
assign indicator_third_o = light_w[2];

// ----------------------------------------------------------------------
// Read port and interrupt
// ----------------------------------------------------------------------
reg [15:0] nxt_rdata;

always @* begin
	nxt_rdata = 16'h0000;
	case (addr_i)
	`PESL_OFF_ESD: begin
		nxt_rdata[`PESL_ESD_MAC_HI:`PESL_ESD_MAC_LO] = esd_mac_ff;
		nxt_rdata[`PESL_ESD_LINE_HI:`PESL_ESD_LINE_LO] = esd_line_ff;
	end
	`PESL_OFF_SGT: begin
		nxt_rdata[`PESL_SGT_HI:`PESL_SGT_LO] = sgt_sel_ff;
		nxt_rdata[11:0] = `PESL_SGT_LOW_RST;
	end
	`PESL_OFF_SGS: begin
		nxt_rdata[`PESL_SGS_PAGE] = sg_page_s;
		nxt_rdata[`PESL_SGS_DONE] = sg_done_s;
	end
	`PESL_OFF_LED: nxt_rdata = led_cfg_ff;
	`PESL_OFF_IRQ_STAT: nxt_rdata[`PESL_IRQ_W-1:0] = irq_stat_ff;
	`PESL_OFF_IRQ_MASK: nxt_rdata[`PESL_IRQ_W-1:0] = irq_mask_ff;
	default: nxt_rdata = 16'h0000;
	endcase
end

always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		rdata_o <= 16'h0000;
		irq_o <= 1'b0;
	end else begin
		rdata_o <= rd_i ? nxt_rdata : 16'h0000;
		irq_o <= |(irq_stat_ff & irq_mask_ff);
	end
end

endmodule

`default_nettype wire

//--- pesl_regs_chk.sv
/* Port checker for the ESD, SGMII timer/status and light register slice.
   Bound to pesl_regs from the testbench top; one clock, reset high. */
`timescale 1ns/1ps
`default_nettype none
module pesl_regs_chk (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [10:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Pins and outputs
	input wire logic sg_page_i,
	input wire logic sg_done_i,
	input wire logic [2:0] mux_first_i,
	input wire logic [1:0] sgmii_timer_sel_o,
	input wire logic sgmii_timer_tick_o,
	input wire logic indicator_first_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (rst_i);
logic [21:0] gap_ff;
logic same_ff;
logic [21:0] lim;
// ----------------------------------------------------------------------
// Cycles between link timer ticks
// ----------------------------------------------------------------------
always_comb begin
	case (sgmii_timer_sel_o)
	2'h0: lim = 22'h061A7F;
	2'h1: lim = 22'h0001F3;
	2'h2: lim = 22'h030D3F;
	default: lim = 22'h29F62F;
	endcase
end
always_ff @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		gap_ff <= 22'h000000;
		same_ff <= 1'b0;
	end else begin
		gap_ff <= sgmii_timer_tick_o ? 22'h000000 : gap_ff + 22'h000001;
		same_ff <= sgmii_timer_tick_o | (same_ff & $stable(sgmii_timer_sel_o));
	end
end
// ----------------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------------
unmapped_read_a: assert property (rd_i && !(addr_i inside {11'h448,
	11'h456, 11'h459, 11'h460, 11'h470, 11'h471, 11'h001})
	|=> rdata_o == 16'h0000) else $error("unmapped read not zero");
timer_rsv_a: assert property (rd_i && addr_i == 11'h456
	|=> rdata_o[15:14] == 2'h0 && rdata_o[11:0] == 12'h008)
	else $error("timer reserved bits wrong");
esd_rsv_a: assert property (rd_i && addr_i == 11'h448
	|=> rdata_o[15:14] == 2'h0 && rdata_o[7:6] == 2'h0)
	else $error("esd reserved bits wrong");
sg_page_a: assert property ($stable(sg_page_i)[*4] ##0
	(rd_i && addr_i == 11'h459) |=> rdata_o[15:1] == {14'h0000,
	$past(sg_page_i)}) else $error("page bit wrong");
sg_done_a: assert property ($stable(sg_done_i)[*4] ##0
	(rd_i && addr_i == 11'h459) |=> rdata_o[0] == $past(sg_done_i))
	else $error("done bit wrong");
timer_write_a: assert property ((wr_i && addr_i == 11'h456) ##1 !wr_i
	|=> sgmii_timer_sel_o == $past(wdata_i[13:12], 2))
	else $error("timer select not written");
timer_reset_a: assert property ($fell(rst_i)
	|-> sgmii_timer_sel_o == 2'h1) else $error("timer reset wrong");
timer_gap_a: assert property (sgmii_timer_tick_o && same_ff
	&& $stable(sgmii_timer_sel_o) |-> gap_ff == lim)
	else $error("timer period wrong");
tick_pulse_a: assert property (sgmii_timer_tick_o
	|=> !sgmii_timer_tick_o) else $error("tick longer than one cycle");
mux_gate_a: assert property ((mux_first_i != 3'h0)[*4]
	|-> !indicator_first_o) else $error("light shown under pin mux");
endmodule
`default_nettype wire

//--- tb.sv
/* Testbench for pesl_regs: reads, ESD counts, interrupt, timer, lights.
   Assumes the design files and pesl_regs_chk are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
logic clk, rst, por, wr, rd, em, el, pg, dn, lk, tx, rx, sl, pe, pc;
logic [10:0] addr;
logic [15:0] wd, rdv;
logic [2:0] m1, m2, m3;
wire [15:0] rdata;
wire [1:0] sel;
wire tick, l1, l2, l3, irq;
int mismatches, comparisons;
pesl_regs uut (.core_clk_i(clk), .rst_i(rst), .por_i(por), .addr_i(addr),
	.wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .esd_mac_i(em),
	.esd_line_i(el), .sg_page_i(pg), .sg_done_i(dn), .link_i(lk),
	.tx_act_i(tx), .rx_act_i(rx), .slave_i(sl), .prbs_err_i(pe),
	.prbs_clr_i(pc), .mux_first_i(m1), .mux_second_i(m2),
	.mux_third_i(m3), .sgmii_timer_sel_o(sel), .sgmii_timer_tick_o(tick),
	.indicator_first_o(l1), .indicator_second_o(l2),
	.indicator_third_o(l3), .irq_o(irq));
initial begin
	clk = 1'b0;
	forever #2 clk = ~clk;
end
task automatic chk(input string n, input logic [15:0] e, g);
	comparisons++;
	if (g !== e) begin
		mismatches++;
		$display("CHECK FAILED %s expected %h seen %h", n, e, g);
	end
endtask
task automatic cyc(input int n);
	repeat (n) @(posedge clk);
	#1;
endtask
task automatic wrr(input logic [10:0] a, input logic [15:0] d);
	@(posedge clk);
	addr <= a;
	wd <= d;
	wr <= 1'b1;
	@(posedge clk);
	wr <= 1'b0;
endtask
task automatic rdr(input logic [10:0] a);
	@(posedge clk);
	addr <= a;
	rd <= 1'b1;
	@(posedge clk);
	rd <= 1'b0;
	#1;
	rdv = rdata;
endtask
task automatic rc(input logic [10:0] a, input logic [15:0] e);
	rdr(a);
	chk($sformatf("read %h", a), e, rdv);
endtask
task automatic lc(input logic e);
	chk("first light", {15'h0000, e}, {15'h0000, l1});
endtask
task automatic lt(input logic [3:0] c, input logic [3:0] in, input logic e);
	wrr(11'h460, {12'h200, c});
	{lk, tx, rx, sl} <= in;
	cyc(6);
	lc(e);
endtask
task automatic test_done;
	$display("comparisons %0d mismatches %0d", comparisons, mismatches);
	if (mismatches == 0 && comparisons > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
// ----------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------
task automatic t_reset;
	rc(11'h460, 16'h2610);
	rc(11'h456, 16'h1008);
	rc(11'h459, 16'h0000);
	rc(11'h448, 16'h0000);
	rc(11'h7FF, 16'h0000);
endtask
task automatic t_esd;
	wrr(11'h471, 16'h0000);
	for (int i = 0; i < 3; i++) begin
		em <= 1'b1;
		el <= i < 2;
		cyc(4);
		em <= 1'b0;
		el <= 1'b0;
		cyc(4);
	end
	rc(11'h448, 16'h0302);
	wrr(11'h448, 16'hFFFF);
	rc(11'h448, 16'h0302);
	rc(11'h470, 16'h0001);
	chk("irq", 16'h0000, {15'h0000, irq});
	wrr(11'h471, 16'h0001);
	cyc(3);
	chk("irq", 16'h0001, {15'h0000, irq});
	wrr(11'h470, 16'h0001);
	cyc(3);
	chk("irq", 16'h0000, {15'h0000, irq});
	rst <= 1'b1;
	cyc(3);
	rst <= 1'b0;
	cyc(2);
	rc(11'h448, 16'h0302);
	por <= 1'b1;
	cyc(3);
	por <= 1'b0;
	cyc(2);
	rc(11'h448, 16'h0000);
endtask
task automatic t_timer;
	int n;
	wrr(11'h456, 16'hFFFF);
	rc(11'h456, 16'h3008);
	for (int s = 0; s < 3; s++) begin
		wrr(11'h456, {2'h0, s[1:0], 12'h000});
		cyc(3);
		chk("timer select", {14'h0000, s[1:0]}, {14'h0000, sel});
		n = 0;
		if (s != 1) begin
			// Long periods: no tick may come within 2000 cycles
			repeat (2000) begin
				cyc(1);
				if (tick !== 1'b0)
					n++;
			end
		end else begin
			while (tick !== 1'b1 && n < 2000) begin
				cyc(1);
				n++;
			end
			n = 0;
			do begin
				cyc(1);
				n++;
			end while (tick !== 1'b1 && n < 2000);
		end
		chk("timer period", s == 1 ? 16'h01F4 : 16'h0000, n[15:0]);
	end
endtask
task automatic t_sgmii;
	pg <= 1'b1;
	cyc(5);
	rc(11'h459, 16'h0002);
	pg <= 1'b0;
	dn <= 1'b1;
	cyc(5);
	rc(11'h459, 16'h0001);
	dn <= 1'b0;
	rc(11'h470, 16'h0006);
endtask
task automatic t_lights;
	lt(4'h0, 4'h8, 1'b1);
	lt(4'h0, 4'h0, 1'b0);
	lt(4'h1, 4'h8, 1'b1);
	lt(4'h6, 4'h8, 1'b0);
	lt(4'h6, 4'h4, 1'b1);
	lt(4'h5, 4'h9, 1'b1);
	lt(4'h5, 4'h8, 1'b0);
	lt(4'h7, 4'hF, 1'b0);
	lt(4'hB, 4'hF, 1'b0);
	lt(4'h0, 4'h8, 1'b1);
	{m1, m2, m3} <= 9'h049;
	cyc(6);
	lc(1'b0);
	chk("second light", 16'h0000, {15'h0000, l2});
	chk("third light", 16'h0000, {15'h0000, l3});
	{m1, m2, m3} <= 9'h000;
	wrr(11'h460, 16'h2B00);
	cyc(6);
	chk("second light", 16'h0001, {15'h0000, l2});
	chk("third light", 16'h0000, {15'h0000, l3});
	wrr(11'h460, 16'h20B0);
	cyc(6);
	chk("second light", 16'h0000, {15'h0000, l2});
	chk("third light", 16'h0001, {15'h0000, l3});
endtask
task automatic t_latch;
	rdr(11'h001);
	lt(4'h9, 4'h8, 1'b0);
	lk <= 1'b0;
	cyc(6);
	lc(1'b1);
	rc(11'h470, 16'h000E);
	lk <= 1'b1;
	cyc(6);
	lc(1'b1);
	rdr(11'h001);
	cyc(6);
	lc(1'b0);
	lt(4'hA, 4'h8, 1'b0);
	pe <= 1'b1;
	cyc(4);
	pe <= 1'b0;
	cyc(6);
	lc(1'b1);
	pc <= 1'b1;
	cyc(4);
	pc <= 1'b0;
	cyc(6);
	lc(1'b0);
endtask
initial begin
	{wr, rd, em, el, pg, dn, lk, tx, rx, sl, pe, pc} = 12'h000;
	{addr, wd, m1, m2, m3} = 36'h0;
	rst = 1'b1;
	por = 1'b1;
	cyc(20);
	rst <= 1'b0;
	por <= 1'b0;
	t_reset;
	t_esd;
	t_timer;
	t_sgmii;
	t_lights;
	t_latch;
	test_done;
end
initial begin
	#100000;
	mismatches++;
	test_done;
end
endmodule
bind pesl_regs pesl_regs_chk chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .sg_page_i(sg_page_i), .sg_done_i(sg_done_i),
	.mux_first_i(mux_first_i), .sgmii_timer_sel_o(sgmii_timer_sel_o),
	.sgmii_timer_tick_o(sgmii_timer_tick_o),
	.indicator_first_o(indicator_first_o));
`default_nettype wire
